// ### hdl/msw_pkg.sv
package msw_pkg;

    localparam int INSTR_W = 10;
    localparam int NIB_W = 4;
    localparam int RAM_AW = 8;
    // opcode field sits above the immediate nibble
    localparam int OPC_LSB = 4;

    // opcode patterns, upper six bits of the instruction word
    localparam logic [5:0] OPC_SWAP = 6'h2D;
    localparam logic [5:0] OPC_SWAP_DEC = 6'h2F;
    localparam logic [5:0] OPC_SWAP_INC = 6'h2E;
    // full words for the watchdog flag clear and disable
    localparam logic [9:0] OPW_WDT_CLEAR = 10'h2A0;
    localparam logic [9:0] OPW_WDT_DISABLE = 10'h29C;

    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [3:0] NIB_ONE = 4'h1;
    localparam logic [3:0] NIB_MAX = 4'hF;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] regX;
        logic [3:0] regY;
    } msw_regs_t;

    typedef struct packed {
        logic wrEn;
        logic [RAM_AW-1:0] addr;
        logic [3:0] wdata;
    } msw_ram_req_t;

    typedef struct packed {
        msw_regs_t regs;
        msw_ram_req_t ram;
        logic skip;
        logic wdtOverflowFlagClr;
        logic wdtStop;
        logic prevWasDisable;
        logic done;
    } msw_state_t;

endpackage

// ### hdl/msw_exec.sv
`timescale 1ns/1ps
module msw_exec
    import msw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic instrValid,
    input wire logic [9:0] instrWord,
    input wire msw_regs_t regsIn,
    input wire logic [7:0] ramDataPointer,
    input wire logic [3:0] ramRdata,
    input wire logic wdtOverflowFlag,
    output msw_regs_t regsOut,
    output msw_ram_req_t ramReq,
    output logic skipNext,
    output logic wdtOverflowFlagClr,
    output logic wdtStop,
    output logic done
);

    // ****************************************
    // decode
    // ****************************************
    function automatic logic isOp(input logic [9:0] w, input logic [5:0] opc);
        return w[INSTR_W-1:OPC_LSB] == opc;
    endfunction

    msw_state_t st;
    msw_state_t next_st;

    logic opSwap;
    logic opDec;
    logic opInc;
    logic opClr;
    logic opDis;
    assign opSwap = instrValid && isOp(instrWord, OPC_SWAP);
    assign opDec = instrValid && isOp(instrWord, OPC_SWAP_DEC);
    assign opInc = instrValid && isOp(instrWord, OPC_SWAP_INC);
    assign opClr = instrValid && instrWord == OPW_WDT_CLEAR;
    assign opDis = instrValid && instrWord == OPW_WDT_DISABLE;

    // ****************************************
    // execute
    // ****************************************
    always_comb begin
        logic [3:0] newY;
        newY = NIB_ZERO;
        next_st = st;
        next_st.regs = regsIn;
        next_st.ram.wrEn = 1'b0;
        next_st.ram.addr = ramDataPointer;
        next_st.ram.wdata = NIB_ZERO;
        next_st.skip = 1'b0;
        next_st.wdtOverflowFlagClr = 1'b0;
        next_st.wdtStop = 1'b0;
        next_st.done = 1'b0;
        // held through idle cycles, so a wait between disable and clear still counts
        if (instrValid) begin
            next_st.prevWasDisable = opDis;
            next_st.done = 1'b1;
        end
        if (opSwap || opDec || opInc) begin
            // memory written with old A, A takes old memory
            next_st.ram.wrEn = 1'b1;
            next_st.ram.wdata = regsIn.acc;
            next_st.regs.acc = ramRdata;
            next_st.regs.regX = regsIn.regX ^ instrWord[NIB_W-1:0];
        end
        if (opDec) begin
            newY = regsIn.regY - NIB_ONE;
            next_st.regs.regY = newY;
            next_st.skip = newY == NIB_MAX;
        end
        if (opInc) begin
            newY = regsIn.regY + NIB_ONE;
            next_st.regs.regY = newY;
            next_st.skip = newY == NIB_ZERO;
        end
        // only a pulse; the flag owner must let a fresh overflow win over it
        if (opClr) begin
            next_st.wdtOverflowFlagClr = 1'b1;
            next_st.skip = wdtOverflowFlag;
            next_st.wdtStop = st.prevWasDisable;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign regsOut = st.regs;
    assign ramReq = st.ram;
    assign skipNext = st.skip;
    assign wdtOverflowFlagClr = st.wdtOverflowFlagClr;
    assign wdtStop = st.wdtStop;
    assign done = st.done;

    // ****************************************
    // checks
    // ****************************************
    property p_clr_skip;
        @(posedge clk) disable iff (rst)
        opClr |=> wdtOverflowFlagClr && skipNext == $past(wdtOverflowFlag);
    endproperty
    a_clr_skip: assert property (p_clr_skip) else $error("flag clear skip wrong");

    property p_stop;
        @(posedge clk) disable iff (rst)
        opDis ##1 opClr |=> wdtStop;
    endproperty
    a_stop: assert property (p_stop) else $error("watchdog not stopped");

    property p_swap;
        @(posedge clk) disable iff (rst)
        (opSwap || opDec || opInc) |=> ramReq.wrEn && ramReq.wdata == $past(regsIn.acc)
            && regsOut.acc == $past(ramRdata) && ramReq.addr == $past(ramDataPointer);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_xor;
        @(posedge clk) disable iff (rst)
        (opSwap || opDec || opInc) |=> regsOut.regX == ($past(regsIn.regX) ^ $past(instrWord[3:0]));
    endproperty
    a_xor: assert property (p_xor) else $error("x xor wrong");

    property p_dec_plain;
        @(posedge clk) disable iff (rst)
        (instrValid && instrWord[9:4] == 6'h2D) |=> ramReq.wrEn && !skipNext;
    endproperty
    a_dec_plain: assert property (p_dec_plain) else $error("plain swap decode");

    property p_dec;
        @(posedge clk) disable iff (rst)
        opDec |=> regsOut.regY == $past(regsIn.regY) - 4'h1
            && skipNext == ($past(regsIn.regY) == 4'h0);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");

    property p_dec_code;
        @(posedge clk) disable iff (rst)
        (instrValid && instrWord[9:4] == 6'h2F) |-> (opDec && !opInc && !opSwap)
            ##1 (ramReq.wrEn && regsOut.regY == $past(regsIn.regY) - 4'h1);
    endproperty
    a_dec_code: assert property (p_dec_code) else $error("dec decode");

    property p_inc;
        @(posedge clk) disable iff (rst)
        opInc |=> regsOut.regY == $past(regsIn.regY) + 4'h1
            && skipNext == ($past(regsIn.regY) == 4'hF);
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");

    property p_inc_code;
        @(posedge clk) disable iff (rst)
        (instrValid && instrWord[9:4] == 6'h2E) |-> (opInc && !opDec && !opSwap)
            ##1 (ramReq.wrEn && regsOut.regY == $past(regsIn.regY) + 4'h1);
    endproperty
    a_inc_code: assert property (p_inc_code) else $error("inc decode");

    // ****************************************
    // quiet unless asked
    // ****************************************
    // stray pulses slip past the per-op checks above, so each output is traced to its cause
    property p_plain_y;
        @(posedge clk) disable iff (rst)
        opSwap |=> regsOut.regY == $past(regsIn.regY) && !skipNext;
    endproperty
    a_plain_y: assert property (p_plain_y) else $error("plain swap touched y");

    property p_refuse;
        @(posedge clk) disable iff (rst)
        (instrValid && !(opSwap || opDec || opInc || opClr)) |=> done && !ramReq.wrEn
            && !skipNext && !wdtOverflowFlagClr && !wdtStop && regsOut == $past(regsIn);
    endproperty
    a_refuse: assert property (p_refuse) else $error("unknown word had an effect");

    property p_quiet;
        @(posedge clk) disable iff (rst)
        !instrValid |=> !done && !ramReq.wrEn && !skipNext && !wdtOverflowFlagClr && !wdtStop;
    endproperty
    a_quiet: assert property (p_quiet) else $error("pulse without instruction");

    property p_done;
        @(posedge clk) disable iff (rst)
        instrValid |=> done;
    endproperty
    a_done: assert property (p_done) else $error("instruction not completed");

    property p_wr_src;
        @(posedge clk) disable iff (rst)
        ramReq.wrEn |-> $past(opSwap || opDec || opInc);
    endproperty
    a_wr_src: assert property (p_wr_src) else $error("ram write without swap");

    property p_skip_src;
        @(posedge clk) disable iff (rst)
        skipNext |-> $past(opClr || opDec || opInc);
    endproperty
    a_skip_src: assert property (p_skip_src) else $error("skip without cause");

    property p_clr_src;
        @(posedge clk) disable iff (rst)
        wdtOverflowFlagClr |-> $past(opClr);
    endproperty
    a_clr_src: assert property (p_clr_src) else $error("flag clear without op");

    property p_clr_regs;
        @(posedge clk) disable iff (rst)
        opClr |=> regsOut == $past(regsIn) && !ramReq.wrEn;
    endproperty
    a_clr_regs: assert property (p_clr_regs) else $error("flag clear touched regs");

    property p_stop_src;
        @(posedge clk) disable iff (rst)
        wdtStop |-> $past(opClr);
    endproperty
    a_stop_src: assert property (p_stop_src) else $error("stop without flag clear");

endmodule

// ### tb/msw_exec_test.sv
`timescale 1ns/1ps
module msw_exec_test;
    import msw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic instrValid = 1'b0;
    logic [9:0] instrWord = 10'h000;
    msw_regs_t regsIn = '0;
    logic [7:0] ramDataPointer = 8'h5A;
    logic [3:0] ramRdata = 4'h0;
    logic wdtOverflowFlag = 1'b0;
    msw_regs_t regsOut;
    msw_ram_req_t ramReq;
    logic skipNext, wdtOverflowFlagClr, wdtStop, done;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    msw_exec dut_u (.clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
        .regsIn(regsIn), .ramDataPointer(ramDataPointer), .ramRdata(ramRdata),
        .wdtOverflowFlag(wdtOverflowFlag), .regsOut(regsOut), .ramReq(ramReq),
        .skipNext(skipNext), .wdtOverflowFlagClr(wdtOverflowFlagClr), .wdtStop(wdtStop),
        .done(done));
    always #5 clk = ~clk;
    // ****************
    // helpers
    // ****************
    task end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard; whole run needs well under a hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 400) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one instruction, sampled in the cycle its pulses stand
    task run(input logic [9:0] w, input msw_regs_t r, input logic [3:0] rd, input logic f,
        input logic [7:0] p);
        @(posedge clk);
        ramDataPointer <= p;
        instrValid <= 1'b1;
        instrWord <= w;
        regsIn <= r;
        ramRdata <= rd;
        wdtOverflowFlag <= f;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
    endtask
    // ****************
    // scenarios
    // ****************
    task t_swap;
        logic [5:0] opc [6];
        logic [3:0] yIn [6];
        logic [3:0] j, ny, rd;
        msw_regs_t r;
        logic sk;
        opc = '{OPC_SWAP, OPC_SWAP_DEC, OPC_SWAP_DEC, OPC_SWAP_INC, OPC_SWAP_INC, OPC_SWAP};
        yIn = '{4'h7, 4'h0, 4'h5, 4'hF, 4'h3, 4'hF};
        for (int i = 0; i < 6; i++) begin
            j = 4'(i * 3);
            rd = 4'(i) + 4'h8;
            r = '{acc: 4'hC ^ 4'(i), regX: 4'h6, regY: yIn[i]};
            ny = (opc[i] == OPC_SWAP) ? yIn[i] : (opc[i] == OPC_SWAP_DEC) ? yIn[i] - 4'h1
                : yIn[i] + 4'h1;
            sk = (opc[i] == OPC_SWAP_DEC) ? (ny == 4'hF) : (opc[i] == OPC_SWAP_INC) && (ny == 4'h0);
            run({opc[i], j}, r, rd, 1'b0, {j, ~j});
            chk({regsOut.acc, regsOut.regX, regsOut.regY, 3'h0, skipNext},
                {rd, r.regX ^ j, ny, 3'h0, sk});
            chk({wdtOverflowFlagClr, wdtStop, ramReq.wrEn, ramReq.addr, ramReq.wdata, done},
                {2'h0, 1'b1, j, ~j, r.acc, 1'b1});
        end
    endtask
    task t_wdt;
        msw_regs_t r;
        r = '{acc: 4'h2, regX: 4'h4, regY: 4'h8};
        for (int f = 0; f < 2; f++) begin
            run(OPW_WDT_CLEAR, r, 4'h0, 1'(f), 8'h00);
            chk({12'h0, wdtOverflowFlagClr, skipNext, wdtStop, ramReq.wrEn},
                {12'h0, 1'b1, 1'(f), 2'h0});
        end
        run(OPW_WDT_DISABLE, r, 4'h0, 1'b0, 8'h00);
        chk({14'h0, wdtStop, done}, 16'h0001);
        run(OPW_WDT_CLEAR, r, 4'h0, 1'b1, 8'h00);
        chk({15'h0, wdtStop}, 16'h0001);
        run(OPW_WDT_CLEAR, r, 4'h0, 1'b0, 8'h00);
        chk({15'h0, wdtStop}, 16'h0000);
        // a swap between disable and clear breaks the pairing
        run(OPW_WDT_DISABLE, r, 4'h0, 1'b0, 8'h00);
        run({OPC_SWAP, 4'h0}, r, 4'h0, 1'b0, 8'h00);
        run(OPW_WDT_CLEAR, r, 4'h0, 1'b1, 8'h00);
        chk({14'h0, wdtStop, skipNext}, 16'h0001);
        // unknown word: only done, registers pass through
        run(10'h000, r, 4'h0, 1'b1, 8'h00);
        chk({regsOut, skipNext, wdtOverflowFlagClr, ramReq.wrEn, done},
            {r, 3'h0, 1'b1});
    endtask
    // reset in mid-run drops the pending disable and every output
    task t_reset;
        msw_regs_t r;
        r = '{acc: 4'h9, regX: 4'h3, regY: 4'h1};
        run(OPW_WDT_DISABLE, r, 4'h0, 1'b0, 8'h00);
        @(posedge clk);
        rst <= 1'b1;
        instrValid <= 1'b1;
        instrWord <= OPW_WDT_CLEAR;
        #1;
        chk({regsOut, done, skipNext, wdtOverflowFlagClr, wdtStop}, 16'h0000);
        @(posedge clk);
        rst <= 1'b0;
        instrValid <= 1'b0;
        #1;
        chk({regsOut, done, skipNext, wdtOverflowFlagClr, wdtStop}, 16'h0000);
        run(OPW_WDT_CLEAR, r, 4'h0, 1'b1, 8'h00);
        chk({14'h0, wdtStop, skipNext}, 16'h0001);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_swap();
        t_wdt();
        t_reset();
        end_of_test();
    end
endmodule
